// ### logic/gsa_top.sv
// Global status aggregator: five status words and the summary byte
// Functional notes
// - Watchdog counter nonzero raises global error
// - Summary byte bit order; codes B9, C0
// - Normal or cleared summary reads 0x20
// - Power-on reads 0x80, weak supply 0x82
// - Stuck input/watchdog A1, thermal A8, regulator A4
// - Five 16-bit words, ten diagnosis groups
// - Bad clock count or parity flags comm error
// - Word-only failure gives 0xA0
// - Open-load bits latch until read-and-clear
`timescale 1ns/1ps
module gsa_top
	import gsa_pkg::*;
(
	input  wire logic          REF_CLK,
	input  wire logic          SYS_RST,
	input  wire gsa_word1_ev_t WORD1_EV,
	input  wire logic [15:0]   WORD2_IN,
	input  wire logic [15:0]   WORD3_IN,
	input  wire logic [15:0]   WORD4_IN,
	input  wire logic [15:0]   WORD5_IN,
	input  wire logic          VLOCKOUT_EN,
	input  wire gsa_glob_ev_t  GLOB_EV,
	input  wire logic          WD_GOOD_TRIGGER,
	input  wire gsa_access_t   ACCESS,
	output logic [15:0]        RD_DATA,
	output logic [7:0]         GLOBAL_STATUS
);
	gsa_phase_t  phase;
	gsa_phase_t  next_phase;
	logic        comm_err;
	logic        next_comm_err;
	logic        therm_one;
	logic        next_therm_one;
	logic        therm_two;
	logic        next_therm_two;
	logic        reg_fail;
	logic        next_reg_fail;
	logic        stuck_in;
	logic        next_stuck_in;
	logic        weak_sup;
	logic        next_weak_sup;
	logic [15:0] next_rd_data;
	logic [15:0] word1;
	logic [15:0] w1_set;
	logic [15:0] w1_mask;
	logic [15:0] words [NUM_WORDS];
	logic        clr_w1;
	logic        clr_w3;
	logic        clr_glob;
	logic        wd_nonzero;
	logic        word_fail;
	logic [7:0]  summary;

	// Access decode, one function used for the word one, word three and global clears
	function automatic logic clr_hit(gsa_access_t a, logic [2:0] s);
		return a.rd && a.clr && (a.sel == s);
	endfunction

	assign clr_w1   = clr_hit(ACCESS, SEL_WORD1);
	assign clr_w3   = clr_hit(ACCESS, SEL_WORD3);
	assign clr_glob = clr_hit(ACCESS, SEL_GLOBAL);

	// Word one sources; supply bits stick only with lockout enabled
	assign w1_set = {WORD1_EV.open_load, WORD1_EV.supply_undervoltage,
		WORD1_EV.aux_regulator_failure, WORD1_EV.aux_regulator_short,
		WORD1_EV.supply_overvoltage, WORD1_EV.overcurrent};
	assign w1_mask = {5'h1f, VLOCKOUT_EN, 2'h3, VLOCKOUT_EN, 7'h7f};

	// Word one latch with read-and-clear
	gsa_latch16 u_word1 (
		.clk         (REF_CLK),
		.rst         (SYS_RST),
		.set_bits    (w1_set),
		.live_bits   (w1_set),
		.sticky_mask (w1_mask),
		.clear       (clr_w1),
		.word        (word1)
	);

	// Five words, two diagnosis groups each
	always_comb begin
		words[0] = word1;
		words[1] = WORD2_IN;
		words[2] = WORD3_IN;
		words[3] = WORD4_IN;
		words[4] = WORD5_IN;
	end

	assign wd_nonzero = WORD3_IN[SW3_WDC_HI:SW3_WDC_LO] != 4'h0;
	// Failures visible only in the words
	// Open-load bits stay out of the global error
	assign word_fail = (word1[SW1_OL_LO-1:0] != 11'h000) ||
		WORD3_IN[SW3_THERM_ONE] || WORD3_IN[SW3_REG_FAIL] ||
		(WORD3_IN[SW3_WDC_HI:SW3_FS_LO] != 6'h00);

	// Sticky global events; a set beats a clear
	always_comb begin
		next_comm_err  = comm_err;
		next_therm_one = therm_one;
		next_therm_two = therm_two;
		next_reg_fail  = reg_fail;
		next_stuck_in  = stuck_in;
		next_weak_sup  = weak_sup;
		next_phase     = phase;
		if (clr_glob || WD_GOOD_TRIGGER) begin
			next_comm_err = 1'b0;
			next_stuck_in = 1'b0;
			next_weak_sup = 1'b0;
			next_phase    = PH_RUNNING;
		end
		if (clr_w3) begin
			next_therm_one = 1'b0;
			next_therm_two = 1'b0;
			next_reg_fail  = 1'b0;
		end
		if (GLOB_EV.bad_clock_count || GLOB_EV.parity_fail) begin
			next_comm_err = 1'b1;
		end
		if (GLOB_EV.thermal_stage_one) begin
			next_therm_one = 1'b1;
		end
		if (GLOB_EV.thermal_stage_two) begin
			next_therm_two = 1'b1;
		end
		if (GLOB_EV.main_regulator_failure) begin
			next_reg_fail = 1'b1;
		end
		if (GLOB_EV.stuck_data_input) begin
			next_stuck_in = 1'b1;
		end
		if (phase == PH_POWER_ON && GLOB_EV.weak_supply_at_power_on) begin
			next_weak_sup = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			comm_err  <= 1'b0;
			therm_one <= 1'b0;
			therm_two <= 1'b0;
			reg_fail  <= 1'b0;
			stuck_in  <= 1'b0;
			weak_sup  <= 1'b0;
			phase     <= PH_POWER_ON;
		end else begin
			comm_err  <= next_comm_err;
			therm_one <= next_therm_one;
			therm_two <= next_therm_two;
			reg_fail  <= next_reg_fail;
			stuck_in  <= next_stuck_in;
			weak_sup  <= next_weak_sup;
			phase     <= next_phase;
		end
	end

	// Summary byte assembly
	always_comb begin
		summary = 8'h00;
		summary[GS_COMM_ERR]    = comm_err;
		summary[GS_NOT_RST_N]   = (phase == PH_RUNNING) && !comm_err;
		summary[GS_THERM_TWO]   = therm_two;
		summary[GS_THERM_ONE]   = therm_one || therm_two;
		summary[GS_REG_FAIL]    = reg_fail;
		summary[GS_SUPPLY_FAIL] = weak_sup || (phase == PH_RUNNING &&
			(word1[SW1_UV] || word1[SW1_OV]));
		summary[GS_FAIL_SAFE]   = wd_nonzero || stuck_in || therm_two;
		summary[GS_GLOBAL_ERR]  = (phase == PH_POWER_ON) ||
			(|summary[6:0] & ~(summary == GS_NORMAL)) ||
			(summary[6:0] != 7'h20 && summary[6:0] != 7'h00) ||
			wd_nonzero || word_fail;
	end

	// Registered read data
	always_comb begin
		next_rd_data = RD_DATA;
		if (ACCESS.rd) begin
			case (ACCESS.sel)
				SEL_GLOBAL: next_rd_data = {8'h00, summary};
				SEL_WORD1:  next_rd_data = words[0];
				SEL_WORD2:  next_rd_data = words[1];
				SEL_WORD3:  next_rd_data = words[2];
				SEL_WORD4:  next_rd_data = words[3];
				SEL_WORD5:  next_rd_data = words[4];
				default:    next_rd_data = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			RD_DATA       <= 16'h0000;
			GLOBAL_STATUS <= GS_POWER_ON;
		end else begin
			RD_DATA       <= next_rd_data;
			GLOBAL_STATUS <= summary;
		end
	end

	a_wd_count_err: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		wd_nonzero |=> GLOBAL_STATUS[GS_GLOBAL_ERR])
		else $error("counter set but no global error");
	a_comm_code: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(GLOB_EV.parity_fail && phase == PH_RUNNING && !wd_nonzero &&
		 !therm_one && !therm_two && !reg_fail && !stuck_in && !word_fail &&
		 !GLOB_EV.thermal_stage_one && !GLOB_EV.thermal_stage_two &&
		 !GLOB_EV.main_regulator_failure && !GLOB_EV.stuck_data_input &&
		 !weak_sup && !clr_glob && !WD_GOOD_TRIGGER)
		|=> ##1 (GLOBAL_STATUS == GS_COMM_CODE || word1[SW1_UV] ||
		 word1[SW1_OV] || wd_nonzero || word_fail))
		else $error("comm error code wrong");
	a_normal_code: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(phase == PH_RUNNING && summary[6:0] == 7'h20 && !wd_nonzero &&
		 !word_fail) |=> GLOBAL_STATUS == GS_NORMAL)
		else $error("normal code not 0x20");
	a_power_on: assert property (@(posedge REF_CLK)
		$fell(SYS_RST) |-> GLOBAL_STATUS == GS_POWER_ON)
		else $error("power-on code not 0x80");
	a_therm_two: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		therm_two |=> GLOBAL_STATUS[4] && GLOBAL_STATUS[3] &&
		GLOBAL_STATUS[0] && GLOBAL_STATUS[7])
		else $error("thermal two bits missing");
	a_stuck_fail: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		stuck_in |=> GLOBAL_STATUS[GS_FAIL_SAFE] &&
		GLOBAL_STATUS[GS_GLOBAL_ERR])
		else $error("stuck input not fail safe");
	a_reg_fail: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		GLOB_EV.main_regulator_failure |=> ##1 GLOBAL_STATUS[GS_REG_FAIL])
		else $error("regulator failure not shown");
	a_word_only: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		word_fail |=> GLOBAL_STATUS[GS_GLOBAL_ERR])
		else $error("word failure not in global");
	a_word_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(ACCESS.rd && ACCESS.sel == SEL_WORD2) |=> RD_DATA == $past(WORD2_IN))
		else $error("word two read wrong");

	c_power_on_weak: cover property (@(posedge REF_CLK)
		GLOBAL_STATUS == GS_POWER_ON_WEAK);
	c_normal: cover property (@(posedge REF_CLK) GLOBAL_STATUS == GS_NORMAL);
	c_therm2: cover property (@(posedge REF_CLK)
		GLOBAL_STATUS == GS_THERM2_CODE);
	c_word1_clear: cover property (@(posedge REF_CLK)
		clr_w1 && word1 != 16'h0000);
endmodule

// ### common/gsa_pkg.sv
// Package for the global status aggregator: layouts, codes and field positions
package gsa_pkg;

	// Global summary byte bit positions
	localparam int GS_GLOBAL_ERR  = 7;
	localparam int GS_COMM_ERR    = 6;
	localparam int GS_NOT_RST_N   = 5;
	localparam int GS_THERM_TWO   = 4;
	localparam int GS_THERM_ONE   = 3;
	localparam int GS_REG_FAIL    = 2;
	localparam int GS_SUPPLY_FAIL = 1;
	localparam int GS_FAIL_SAFE   = 0;

	// Reference summary codes
	localparam logic [7:0] GS_NORMAL       = 8'h20;
	localparam logic [7:0] GS_POWER_ON     = 8'h80;
	localparam logic [7:0] GS_POWER_ON_WEAK = 8'h82;
	localparam logic [7:0] GS_COMM_CODE    = 8'hc0;
	localparam logic [7:0] GS_SUPPLY_CODE  = 8'ha2;
	localparam logic [7:0] GS_WD_CODE      = 8'ha1;
	localparam logic [7:0] GS_THERM1_CODE  = 8'ha8;
	localparam logic [7:0] GS_THERM2_CODE  = 8'hb9;
	localparam logic [7:0] GS_REG_CODE     = 8'ha4;
	localparam logic [7:0] GS_OTHER_CODE   = 8'ha0;

	// Status word three field positions
	localparam int SW3_THERM_ONE = 15;
	localparam int SW3_REG_FAIL  = 11;
	localparam int SW3_WDC_HI    = 7;
	localparam int SW3_WDC_LO    = 4;
	localparam int SW3_FS_LO     = 2; // Lowest forced-sleep bit

	// Status word one: open-load bits 15..11, under 10, over 7
	localparam int SW1_OL_HI = 15;
	localparam int SW1_OL_LO = 11;
	localparam int SW1_UV    = 10;
	localparam int SW1_OV    = 7;

	// Status word selectors
	localparam logic [2:0] SEL_WORD1  = 3'h1;
	localparam logic [2:0] SEL_WORD2  = 3'h2;
	localparam logic [2:0] SEL_WORD3  = 3'h3;
	localparam logic [2:0] SEL_WORD4  = 3'h4;
	localparam logic [2:0] SEL_WORD5  = 3'h5;
	localparam logic [2:0] SEL_GLOBAL = 3'h0;
	localparam int         NUM_WORDS  = 5;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// Phase of the summary byte
	typedef enum logic [1:0] {
		PH_POWER_ON = 2'b00,
		PH_RUNNING  = 2'b01
	} gsa_phase_t;

	// Event inputs that feed status word one
	typedef struct packed {
		logic [4:0] open_load;
		logic       supply_undervoltage;
		logic       supply_overvoltage;
		logic       aux_regulator_failure;
		logic       aux_regulator_short;
		logic [6:0] overcurrent;
	} gsa_word1_ev_t;

	// Global event pulses and levels
	typedef struct packed {
		logic thermal_stage_one;
		logic thermal_stage_two;
		logic main_regulator_failure;
		logic stuck_data_input;
		logic bad_clock_count;
		logic parity_fail;
		logic weak_supply_at_power_on;
	} gsa_glob_ev_t;

	// Host access strobe group
	typedef struct packed {
		logic       rd;
		logic       clr;
		logic [2:0] sel;
	} gsa_access_t;

endpackage

// ### logic/gsa_latch16.sv
// Sticky 16-bit status word with read-and-clear
`timescale 1ns/1ps
module gsa_latch16
	import gsa_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] set_bits,
	input  wire logic [15:0] live_bits,
	input  wire logic [15:0] sticky_mask,
	input  wire logic        clear,
	output logic      [15:0] word
);
	logic [15:0] latched;
	logic [15:0] next_latched;

	// Sticky bits: a set in the clear cycle wins
	always_comb begin
		if (clear) begin
			next_latched = set_bits & sticky_mask;
		end else begin
			next_latched = latched | (set_bits & sticky_mask);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			latched <= WORD_RESET;
		end else begin
			latched <= next_latched;
		end
	end

	// Live bits follow their source directly
	assign word = latched | (live_bits & ~sticky_mask);

	a_clear_keeps_set: assert property (@(posedge clk) disable iff (rst)
		(clear && (set_bits & sticky_mask) != 16'h0000) |=>
		((latched & $past(set_bits & sticky_mask))
			== $past(set_bits & sticky_mask)))
		else $error("set lost in clear cycle");
endmodule

// ### test/gsa_host.sv
// Host model: issues register reads on the access strobe group
`timescale 1ns/1ps
module gsa_host
	import gsa_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [15:0] rd_data,
	output gsa_access_t      acc
);
	// Idle strobes from time zero
	initial begin
		acc = '0;
	end

	// One read: strobe held for exactly one taking edge
	task automatic read(input logic [2:0] s, input logic c,
		output logic [15:0] d);
		@(posedge clk);
		acc <= '{rd: 1'b1, clr: c, sel: s};
		@(posedge clk);
		acc <= '0;
		@(posedge clk);
		#1;
		d = rd_data; // Data stands until the next read
	endtask
endmodule

// ### test/test_gsa_top.sv
// Self-checking bench for the global status aggregator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	fails++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module test_gsa_top
	import gsa_pkg::*;
;
	logic          ref_clk, sys_rst, vlock, wd_trig;
	gsa_word1_ev_t w1_ev;
	logic [15:0]   w2, w3, w4, w5, rd_data, d, v;
	gsa_glob_ev_t  g_ev;
	gsa_access_t   acc;
	logic [7:0]    glob_st, ex_ok;
	logic [4:0]    ol;
	int            fails, n_tests;
	gsa_glob_ev_t  ev_tab[6];
	logic [7:0]    ex_tab[6];

	gsa_top i_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .WORD1_EV(w1_ev),
		.WORD2_IN(w2), .WORD3_IN(w3), .WORD4_IN(w4), .WORD5_IN(w5),
		.VLOCKOUT_EN(vlock), .GLOB_EV(g_ev), .WD_GOOD_TRIGGER(wd_trig),
		.ACCESS(acc), .RD_DATA(rd_data), .GLOBAL_STATUS(glob_st));
	gsa_host i_host (.clk(ref_clk), .rd_data(rd_data), .acc(acc));

	// Clock at 40 MHz
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Summary byte built from its flags
	function automatic logic [7:0] code_of(input bit ge, ce, nr, t2, t1,
		rf, sf, fs);
		code_of = '0;
		code_of[GS_GLOBAL_ERR] = ge;
		code_of[GS_COMM_ERR] = ce;
		code_of[GS_NOT_RST_N] = nr;
		code_of[GS_THERM_TWO] = t2;
		code_of[GS_THERM_ONE] = t1;
		code_of[GS_REG_FAIL] = rf;
		code_of[GS_SUPPLY_FAIL] = sf;
		code_of[GS_FAIL_SAFE] = fs;
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Byte settles two edges after the event
	task automatic chk_glob(input logic [7:0] ex, input string nm);
		tick(3);
		`CHK(nm, ex, glob_st)
	endtask

	task automatic pulse(input gsa_glob_ev_t e);
		@(posedge ref_clk);
		g_ev <= e;
		@(posedge ref_clk);
		g_ev <= '0;
	endtask

	task automatic trig();
		@(posedge ref_clk);
		wd_trig <= 1'b1;
		@(posedge ref_clk);
		wd_trig <= 1'b0;
	endtask

	task automatic report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{w1_ev, w2, w3, w4, w5, vlock, g_ev, wd_trig} = '0;
		fails = 0;
		n_tests = 0;
		ex_ok = code_of(0, 0, 1, 0, 0, 0, 0, 0);
		void'($urandom(35334));
		// Stuck input, thermal one, thermal two, regulator, clock, parity
		ev_tab = '{7'h08, 7'h40, 7'h20, 7'h10, 7'h04, 7'h02};
		ex_tab = '{code_of(1, 0, 1, 0, 0, 0, 0, 1),
			code_of(1, 0, 1, 0, 1, 0, 0, 0),
			code_of(1, 0, 1, 1, 1, 0, 0, 1),
			code_of(1, 0, 1, 0, 0, 1, 0, 0),
			code_of(1, 1, 0, 0, 0, 0, 0, 0),
			code_of(1, 1, 0, 0, 0, 0, 0, 0)};
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1;
		`CHK("power-on byte", code_of(1, 0, 0, 0, 0, 0, 0, 0),
			glob_st)
		`CHK("reset data", 16'h0000, rd_data)
		trig();
		chk_glob(ex_ok, "normal byte");
		// Watchdog failure counter nonzero
		@(posedge ref_clk);
		w3 <= {8'h00, 4'($urandom_range(1, 15)), 4'h0};
		chk_glob(code_of(1, 0, 1, 0, 0, 0, 0, 1),
			"wd counter");
		@(posedge ref_clk);
		w3 <= '0;
		trig();
		chk_glob(ex_ok, "wd cleared");
		// Each global event except weak supply, then full clear
		for (int i = 0; i < 6; i++) begin
			pulse(ev_tab[i]);
			chk_glob(ex_tab[i], "event byte");
			i_host.read(SEL_GLOBAL, 1'b1, d);
			`CHK("global read", {8'h00, ex_tab[i]}, d)
			i_host.read(SEL_WORD3, 1'b1, d);
			trig();
			chk_glob(ex_ok, "cleared");
		end
		// Open-load alone latches but stays out of the summary
		ol = 5'($urandom_range(1, 31));
		@(posedge ref_clk);
		w1_ev.open_load <= ol;
		@(posedge ref_clk);
		w1_ev <= '0;
		chk_glob(ex_ok, "open-load only");
		// Relay overcurrent is a word-only failure
		@(posedge ref_clk);
		w1_ev.overcurrent <= 7'h01;
		@(posedge ref_clk);
		w1_ev <= '0;
		chk_glob(code_of(1, 0, 1, 0, 0, 0, 0, 0),
			"word only");
		for (int i = 0; i < 4; i++) begin
			i_host.read(SEL_WORD1, i == 2, d);
			v = (i == 3) ? 16'h0000 : {ol, 11'h001};
			`CHK("word one", v, d)
		end
		chk_glob(ex_ok, "rc byte");
		// Sticky undervoltage with lockout, then live overvoltage
		@(posedge ref_clk);
		vlock <= 1'b1;
		w1_ev.supply_undervoltage <= 1'b1;
		@(posedge ref_clk);
		w1_ev <= '0;
		chk_glob(code_of(1, 0, 1, 0, 0, 0, 1, 0),
			"sticky supply");
		i_host.read(SEL_WORD1, 1'b1, d);
		`CHK("supply word", 16'h0001 << SW1_UV, d)
		@(posedge ref_clk);
		vlock <= 1'b0;
		w1_ev.supply_overvoltage <= 1'b1;
		chk_glob(code_of(1, 0, 1, 0, 0, 0, 1, 0),
			"live supply");
		@(posedge ref_clk);
		w1_ev <= '0;
		chk_glob(ex_ok, "supply gone");
		// Live words two to five, then unused selectors
		for (int k = 2; k < 8; k++) begin
			v = (k > 5) ? 16'h0000 : 16'($urandom);
			if (k == 3) v = v & 16'h770f;
			@(posedge ref_clk);
			case (k)
				2: w2 <= v;
				3: w3 <= v;
				4: w4 <= v;
				5: w5 <= v;
				default: w5 <= '0;
			endcase
			i_host.read(3'(k), 1'b0, d);
			`CHK("status word", v, d)
		end
		@(posedge ref_clk);
		{w2, w3, w4} <= '0;
		// Power-on with weak supply
		g_ev.weak_supply_at_power_on <= 1'b1;
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		chk_glob(code_of(1, 0, 0, 0, 0, 0, 1, 0),
			"weak power-on");
		@(posedge ref_clk);
		g_ev <= '0;
		trig();
		chk_glob(ex_ok, "after weak");
		report_and_stop();
	end
endmodule
